/* fcrb_bench.sv */
// Self-checking APB bench for the flash control register bank
`timescale 1ns/1ps
`default_nettype none
`include "fcrb_regs.svh"

module fcrb_bench;
  import fcrb_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  localparam logic [15:0] A_STG = 16'(`FCRB_IDX_STAGING * 4);
  localparam logic [15:0] A_KEY = 16'(`FCRB_IDX_COMMIT * 4);
  localparam logic [15:0] A_STB = 16'(`FCRB_IDX_STANDBY * 4);
  localparam logic [15:0] A_PIN = 16'(`FCRB_IDX_PORTIN * 4);
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic        serial_prog_mode, exec_from_ram, flash_access, cmd_seq_enable, flash_active;
  logic        boot_rom_a, rom_select_active, standby_request_bit, standby_reset;
  logic        serial_clk_input_en, other_port_input_en;
  logic [1:0]  window_map_active;
  logic [3:0]  pstrb;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  int          fail_count, cmp_count;

  fcrb_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_prog_mode(serial_prog_mode), .exec_from_ram(exec_from_ram), .flash_access(flash_access),
    .cmd_seq_enable(cmd_seq_enable), .flash_active(flash_active), .boot_rom_a(boot_rom_a),
    .window_map_active(window_map_active), .rom_select_active(rom_select_active),
    .standby_request_bit(standby_request_bit), .standby_reset(standby_reset),
    .serial_clk_input_en(serial_clk_input_en), .other_port_input_en(other_port_input_en));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Entered right after an edge; leaves one idle cycle so psel is never driven twice at once
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic err);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rdat);
    chk("pslverr", 32'(err), 32'(rerr));
  endtask : rd

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, serial_prog_mode, exec_from_ram, flash_access} = 7'h0;
    paddr = 16'h0;
    pwdata = 32'h0;
    pstrb = 4'h1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_STG, 32'h40, 1'b0);
    rd(A_KEY, 32'h00, 1'b0);
    rd(A_STB, 32'h00, 1'b0);
    rd(A_PIN, 32'h00, 1'b0);
    chk("cmd_seq_enable", 32'h0, 32'(cmd_seq_enable));
    wr(A_STG, 8'hb8);
    rd(A_STG, 32'hb8, 1'b0);
    rd(A_KEY, 32'h00, 1'b0);
    wr(A_KEY, 8'h55);
    rd(A_KEY, 32'h00, 1'b0);
    chk("flash_active", 32'h0, 32'(flash_active));
    wr(A_KEY, 8'hd5);
    rd(A_KEY, 32'h38, 1'b0);
    chk("flash_active", 32'h1, 32'(flash_active));
    chk("cmd_seq_enable", 32'h1, 32'(cmd_seq_enable));
    chk("window", 32'h2, 32'(window_map_active));
    chk("boot_rom_a", 32'h1, 32'(boot_rom_a));
    wr(A_STG, 8'h42);
    wr(A_KEY, 8'hd5);
    rd(A_KEY, 32'h02, 1'b0);
    chk("cmd_seq_enable", 32'h0, 32'(cmd_seq_enable));
    chk("window", 32'h0, 32'(window_map_active));
    chk("rom_select", 32'h1, 32'(rom_select_active));
    pstrb <= 4'h0;
    wr(A_STG, 8'hb8);
    pstrb <= 4'h1;
    rd(A_STG, 32'h42, 1'b0);
    serial_prog_mode <= 1'b1;
    rd(A_KEY, 32'h12, 1'b0);
    chk("other_en", 32'h0, 32'(other_port_input_en));
    wr(A_PIN, 8'h02);
    chk("sclk_en", 32'h1, 32'(serial_clk_input_en));
    chk("other_en", 32'h0, 32'(other_port_input_en));
    wr(A_PIN, 8'h01);
    rd(A_PIN, 32'h01, 1'b0);
    chk("sclk_en", 32'h0, 32'(serial_clk_input_en));
    chk("other_en", 32'h1, 32'(other_port_input_en));
    serial_prog_mode <= 1'b0;
    wr(A_PIN, 8'h00);
    rd(A_PIN, 32'h00, 1'b0);
    chk("in_en", 32'h3, 32'({serial_clk_input_en, other_port_input_en}));
    wr(A_STB, 8'h01);
    chk("standby", 32'h0, 32'(standby_request_bit));
    exec_from_ram <= 1'b1;
    wr(A_STB, 8'h01);
    rd(A_STB, 32'h00, 1'b0);
    chk("standby", 32'h1, 32'(standby_request_bit));
    flash_access <= 1'b1;
    @(posedge pclk);
    flash_access <= 1'b0;
    @(posedge pclk);
    chk("standby_reset", 32'h1, 32'(standby_reset));
    @(posedge pclk);
    chk("standby_reset", 32'h0, 32'(standby_reset));
    wr(A_STB, 8'h00);
    chk("standby", 32'h0, 32'(standby_request_bit));
    rd(16'h3f50, 32'h00, 1'b1);
    results();
  end
endmodule : fcrb_bench
`default_nettype wire

/* fcrb_pkg.sv */
// Types shared by the flash control bank
package fcrb_pkg;
  typedef enum logic [1:0] {
    FCRB_IDLE   = 2'b01,
    FCRB_ACCESS = 2'b10
  } fcrb_phase_t;

  typedef struct packed {
    fcrb_phase_t phase;
    logic [7:0]  staging;
    logic [2:0]  act_unlock;
    logic        act_boot;
    logic [1:0]  act_window;
    logic        act_romsel;
    logic        flash_active;
    logic        standby;
    logic        sclk_bit;
    logic        other_bit;
    logic        sclk_en;
    logic        other_en;
    logic        standby_rst;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } fcrb_state_t;
endpackage : fcrb_pkg

/* fcrb_regs.svh */
// Register offsets, field positions and reset values of the flash control bank
// Operation
// - The controlled flash array holds 16384 bytes.
// - Staging writes only store; active copy loads only on commit key write.
// - Disable pattern after reset; only active enable pattern permits commands.
// - Window 00 is standard; 10 maps code C000-FFFF onto data C000-FFFF.
// - Commit register is write-only; only the key transfers staged settings.
// - Key commit with enable pattern staged puts the flash array active.
// - Monitor at commit address reads active unlock, boot, window, ROM select.
// - Unlock flag reads 1 only when enable pattern is active.
// - Monitor bits 7 and 6 always read zero.
// - In serial mode boot-map monitor bit always reads 1.
// - Standby bit: 0 disables, 1 enables standby; resets to 0.
// - Standby bit writes accepted only from code running in RAM.
// - Flash access while standby bit is 1 triggers a standby reset.
// - Standby register reads all zero.
// - Serial mode: serial clock input bit blocks at 0, passes at 1.
// - Other-port bit gates all port inputs except serial rx, tx, clock.
// - Processor mode: port input register ignores writes, reads zero.
// - Processor mode keeps all port inputs enabled.
`ifndef FCRB_REGS_SVH
`define FCRB_REGS_SVH
// Printed offsets are word indices; byte address is four times the index
`define FCRB_IDX_STAGING   16'h0fd0
`define FCRB_IDX_COMMIT    16'h0fd1
`define FCRB_IDX_STANDBY   16'h0fd2
`define FCRB_IDX_PORTIN    16'h0fd3
`define FCRB_COMMIT_KEY    8'hd5
`define FCRB_UNLOCK_EN     3'h5
`define FCRB_UNLOCK_DIS    3'h2
`define FCRB_WIN_STD       2'h0
`define FCRB_WIN_HIGH      2'h2
`define FCRB_STAGING_RST   8'h40
`define FCRB_POS_UNLOCK    5
`define FCRB_POS_BOOT      4
`define FCRB_POS_WIN       2
`define FCRB_POS_ROMSEL    1
`define FCRB_POS_FLAG      5
`define FCRB_POS_SCLK_EN   1
`define FCRB_POS_OTHER_EN  0
`define FCRB_FLASH_BYTES   16384
`endif

/* fcrb_top.sv */
// Flash control register bank with APB slave
`timescale 1ns/1ps
`default_nettype none
`include "fcrb_regs.svh"

module fcrb_top #(
  parameter int FLASH_BYTES = `FCRB_FLASH_BYTES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        serial_prog_mode,
  input  wire logic        exec_from_ram,
  input  wire logic        flash_access,
  output logic             cmd_seq_enable,
  output logic             flash_active,
  output logic             boot_rom_a,
  output logic [1:0]       window_map_active,
  output logic             rom_select_active,
  output logic             standby_request_bit,
  output logic             standby_reset,
  output logic             serial_clk_input_en,
  output logic             other_port_input_en
);
  import fcrb_pkg::*;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (FLASH_BYTES != `FCRB_FLASH_BYTES) begin : g_bad_size
    $error("flash size not supported");
  end

  function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
    hit = (a == {idx[13:0], 2'b00});
  endfunction : hit

  fcrb_state_t st;
  fcrb_state_t next_st;

  logic setup;
  logic wr_done;
  logic key_wr;
  logic lo_lane;
  logic addr_known;

  assign setup   = psel && !penable;
  assign wr_done = psel && penable && st.pready && pwrite;
  assign lo_lane = pstrb[0];
  assign addr_known = hit(paddr, `FCRB_IDX_STAGING) ||
                      hit(paddr, `FCRB_IDX_COMMIT) ||
                      hit(paddr, `FCRB_IDX_STANDBY) ||
                      hit(paddr, `FCRB_IDX_PORTIN);
  assign key_wr  = wr_done && lo_lane && hit(paddr, `FCRB_IDX_COMMIT) &&
                   (pwdata[7:0] == `FCRB_COMMIT_KEY);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    next_st.standby_rst = 1'b0;
    next_st.pready      = 1'b0;
    next_st.pslverr     = 1'b0;
    unique case (st.phase)
      FCRB_IDLE: begin
        if (setup) begin
          next_st.phase  = FCRB_ACCESS;
          next_st.pready = 1'b1;
          next_st.prdata = 32'h0000_0000;
          if (hit(paddr, `FCRB_IDX_STAGING)) begin
            next_st.prdata[7:0] = st.staging;
          end else if (hit(paddr, `FCRB_IDX_COMMIT)) begin
            // Same address: writes hit the key, reads see the active copy
            next_st.prdata[`FCRB_POS_FLAG] = (st.act_unlock == `FCRB_UNLOCK_EN);
            next_st.prdata[`FCRB_POS_BOOT] = st.act_boot | serial_prog_mode;
            next_st.prdata[`FCRB_POS_WIN +: 2] = st.act_window;
            next_st.prdata[`FCRB_POS_ROMSEL] = st.act_romsel;
          end else if (hit(paddr, `FCRB_IDX_STANDBY)) begin
            next_st.prdata = 32'h0000_0000;
          end else if (hit(paddr, `FCRB_IDX_PORTIN)) begin
            if (serial_prog_mode) begin
              next_st.prdata[`FCRB_POS_SCLK_EN]  = st.sclk_bit;
              next_st.prdata[`FCRB_POS_OTHER_EN] = st.other_bit;
            end
          end else begin
            next_st.pslverr = 1'b1;
          end
        end
      end
      FCRB_ACCESS: begin
        next_st.phase = FCRB_IDLE;
        if (wr_done && lo_lane && !st.pslverr) begin
          if (hit(paddr, `FCRB_IDX_STAGING)) begin
            next_st.staging = pwdata[7:0];
          end
          if (hit(paddr, `FCRB_IDX_STANDBY) && exec_from_ram) begin
            next_st.standby = pwdata[0];
          end
          if (hit(paddr, `FCRB_IDX_PORTIN) && serial_prog_mode) begin
            next_st.sclk_bit  = pwdata[`FCRB_POS_SCLK_EN];
            next_st.other_bit = pwdata[`FCRB_POS_OTHER_EN];
          end
        end
        if (key_wr) begin
          // Other values fall through and change nothing
          next_st.act_unlock   = st.staging[`FCRB_POS_UNLOCK +: 3];
          next_st.act_boot     = st.staging[`FCRB_POS_BOOT];
          next_st.act_window   = st.staging[`FCRB_POS_WIN +: 2];
          next_st.act_romsel   = st.staging[`FCRB_POS_ROMSEL];
          next_st.flash_active = (st.staging[`FCRB_POS_UNLOCK +: 3] == `FCRB_UNLOCK_EN);
        end
      end
    endcase
    // A flash access in standby resets the array; bit survives for RAM code
    if (st.standby && flash_access) begin
      next_st.standby_rst = 1'b1;
    end
    // Processor mode forces every input open whatever the bits hold
    next_st.sclk_en  = serial_prog_mode ? next_st.sclk_bit : 1'b1;
    next_st.other_en = serial_prog_mode ? next_st.other_bit : 1'b1;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st              <= '0;
      st.phase        <= FCRB_IDLE;
      st.staging      <= `FCRB_STAGING_RST;
      st.act_unlock   <= `FCRB_UNLOCK_DIS;
      st.act_window   <= `FCRB_WIN_STD;
      st.sclk_en      <= 1'b1;
      st.other_en     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata              = st.prdata;
  assign pready              = st.pready;
  assign pslverr             = st.pslverr;
  // Flash active is loaded with the same compare as the unlock copy, so one flop serves both
  assign cmd_seq_enable      = st.flash_active;
  assign flash_active        = st.flash_active;
  assign boot_rom_a          = st.act_boot;
  assign window_map_active   = st.act_window;
  assign rom_select_active   = st.act_romsel;
  assign standby_request_bit = st.standby;
  assign standby_reset       = st.standby_rst;
  assign serial_clk_input_en = st.sclk_en;
  assign other_port_input_en = st.other_en;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_staging_only_store: assert property (
    wr_done && hit(paddr, `FCRB_IDX_STAGING) && !key_wr |=> $stable(st.act_unlock))
    else $error("staging write changed active copy");
  a_commit_loads_copy: assert property (
    key_wr |=> st.act_unlock == $past(st.staging[7:5]) && st.act_window == $past(st.staging[3:2]))
    else $error("commit key did not load active copy");
  a_nonkey_no_change: assert property (
    !key_wr |=> $stable(st.act_unlock) && $stable(st.act_boot) && $stable(st.act_window))
    else $error("active copy changed without key");
  a_active_on_enable: assert property (
    key_wr && st.staging[7:5] == `FCRB_UNLOCK_EN |=> flash_active)
    else $error("flash not active after enabled commit");
  a_cmd_gate_locked: assert property (
    st.act_unlock != `FCRB_UNLOCK_EN |-> !cmd_seq_enable)
    else $error("commands enabled while locked");
  a_monitor_top_zero: assert property (
    pready && hit(paddr, `FCRB_IDX_COMMIT) |-> prdata[7:6] == 2'b00)
    else $error("monitor top bits not zero");
  a_boot_serial_one: assert property (
    setup && serial_prog_mode && hit(paddr, `FCRB_IDX_COMMIT) |=> prdata[4])
    else $error("boot monitor not 1 in serial mode");
  a_standby_reads_zero: assert property (
    setup && hit(paddr, `FCRB_IDX_STANDBY) |=> prdata == 32'h0)
    else $error("standby register read nonzero");
  a_standby_ram_only: assert property (
    wr_done && hit(paddr, `FCRB_IDX_STANDBY) && !exec_from_ram |=> $stable(st.standby))
    else $error("standby written from flash code");
  a_standby_reset: assert property (
    st.standby && flash_access |=> standby_reset)
    else $error("missing standby reset");
  a_mcu_inputs_open: assert property (
    !serial_prog_mode ##1 !serial_prog_mode |-> serial_clk_input_en && other_port_input_en)
    else $error("inputs gated in processor mode");
  a_portin_mcu_write: assert property (
    wr_done && hit(paddr, `FCRB_IDX_PORTIN) && !serial_prog_mode |=> $stable(st.other_bit))
    else $error("port input written in processor mode");

  // ****************************************
  // Bus response
  // ****************************************
  // Zero wait states: one ready pulse per setup

  a_ready_one_cycle: assert property (
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  a_no_ready_idle: assert property (
    !psel |=> !pready)
    else $error("ready without select");

  a_idle_no_err: assert property (
    !psel |=> !pslverr)
    else $error("error without select");

  a_ready_after_setup: assert property (
    setup && st.phase == FCRB_IDLE |=> pready)
    else $error("no ready after setup");

  a_access_one_cycle: assert property (
    st.phase == FCRB_ACCESS |=> st.phase == FCRB_IDLE)
    else $error("access phase not left");

  a_err_with_ready: assert property (
    pslverr |-> pready)
    else $error("error without ready");

  a_err_unmapped: assert property (
    setup && st.phase == FCRB_IDLE && !addr_known |=> pslverr)
    else $error("unmapped address not refused");

  a_mapped_no_err: assert property (
    setup && st.phase == FCRB_IDLE && addr_known |=> !pslverr)
    else $error("mapped address refused");

  a_upper_zero: assert property (
    pready |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  // ****************************************
  // Read views
  // ****************************************
  // Data is captured at setup, so it reflects state before the access

  a_staging_readback: assert property (
    setup && st.phase == FCRB_IDLE && hit(paddr, `FCRB_IDX_STAGING) |=> prdata[7:0] == $past(st.staging))
    else $error("staging read mismatch");

  a_monitor_flag: assert property (
    setup && st.phase == FCRB_IDLE && hit(paddr, `FCRB_IDX_COMMIT) |=>
    prdata[5] == ($past(st.act_unlock) == `FCRB_UNLOCK_EN))
    else $error("unlock flag mismatch");

  a_monitor_window: assert property (
    setup && st.phase == FCRB_IDLE && hit(paddr, `FCRB_IDX_COMMIT) |=> prdata[3:2] == $past(st.act_window))
    else $error("window monitor mismatch");

  a_monitor_romsel: assert property (
    setup && st.phase == FCRB_IDLE && hit(paddr, `FCRB_IDX_COMMIT) |=> prdata[1] == $past(st.act_romsel))
    else $error("rom select monitor mismatch");

  a_monitor_bit0: assert property (
    setup && st.phase == FCRB_IDLE && hit(paddr, `FCRB_IDX_COMMIT) |=> !prdata[0])
    else $error("monitor bit 0 not zero");

  a_boot_mcu_view: assert property (
    setup && st.phase == FCRB_IDLE && !serial_prog_mode && hit(paddr, `FCRB_IDX_COMMIT) |=>
    prdata[4] == $past(st.act_boot))
    else $error("boot monitor mismatch");

  // ****************************************
  // Staging and commit
  // ****************************************
  // Only the key moves staged settings into the active copy

  a_staging_write: assert property (
    wr_done && lo_lane && hit(paddr, `FCRB_IDX_STAGING) |=> st.staging == $past(pwdata[7:0]))
    else $error("staging write lost");

  a_strobe_gates: assert property (
    wr_done && !lo_lane |=> $stable(st.staging) && $stable(st.standby))
    else $error("write without strobe took effect");

  a_staging_survives_key: assert property (
    key_wr |=> $stable(st.staging))
    else $error("commit changed staging");

  a_commit_boot: assert property (
    key_wr |=> st.act_boot == $past(st.staging[4]) && st.act_romsel == $past(st.staging[1]))
    else $error("commit did not load boot or rom select");

  a_key_flash_off: assert property (
    key_wr && st.staging[7:5] != `FCRB_UNLOCK_EN |=> !flash_active)
    else $error("flash active after locked commit");

  a_flash_hold: assert property (
    !key_wr |=> $stable(flash_active))
    else $error("flash active changed without key");

  a_flash_implies_unlock: assert property (
    flash_active |-> st.act_unlock == `FCRB_UNLOCK_EN)
    else $error("flash active while locked");

  a_cmd_follows_unlock: assert property (
    cmd_seq_enable == (st.act_unlock == `FCRB_UNLOCK_EN))
    else $error("command enable does not follow unlock");

  // ****************************************
  // Standby
  // ****************************************
  // The standby bit only moves on a strobed write from RAM code

  a_standby_ram_write: assert property (
    wr_done && lo_lane && hit(paddr, `FCRB_IDX_STANDBY) && exec_from_ram |=> st.standby == $past(pwdata[0]))
    else $error("standby write from RAM lost");

  a_standby_hold: assert property (
    !(wr_done && hit(paddr, `FCRB_IDX_STANDBY)) |=> $stable(standby_request_bit))
    else $error("standby bit changed without write");

  a_standby_pulse_only: assert property (
    !(st.standby && flash_access) |=> !standby_reset)
    else $error("spurious standby reset");

  // ****************************************
  // Port input gating
  // ****************************************
  // Enables update on the same edge as the bits in serial mode

  a_portin_serial_read: assert property (
    setup && st.phase == FCRB_IDLE && serial_prog_mode && hit(paddr, `FCRB_IDX_PORTIN) |=>
    prdata[1:0] == {$past(st.sclk_bit), $past(st.other_bit)})
    else $error("port input read mismatch");

  a_portin_mcu_zero: assert property (
    setup && st.phase == FCRB_IDLE && !serial_prog_mode && hit(paddr, `FCRB_IDX_PORTIN) |=> prdata == 32'h0)
    else $error("port input read nonzero in processor mode");

  a_portin_serial_write: assert property (
    wr_done && lo_lane && hit(paddr, `FCRB_IDX_PORTIN) && serial_prog_mode |=>
    st.sclk_bit == $past(pwdata[1]) && st.other_bit == $past(pwdata[0]))
    else $error("port input write lost");

  a_portin_mcu_sclk: assert property (
    wr_done && hit(paddr, `FCRB_IDX_PORTIN) && !serial_prog_mode |=> $stable(st.sclk_bit))
    else $error("clock input bit written in processor mode");

  a_serial_sclk_gate: assert property (
    serial_prog_mode |=> serial_clk_input_en == st.sclk_bit)
    else $error("serial clock gate mismatch");

  a_serial_other_gate: assert property (
    serial_prog_mode |=> other_port_input_en == st.other_bit)
    else $error("other port gate mismatch");

  a_mcu_sclk_open: assert property (
    !serial_prog_mode |=> serial_clk_input_en)
    else $error("serial clock gated in processor mode");

  a_mcu_other_open: assert property (
    !serial_prog_mode |=> other_port_input_en)
    else $error("other ports gated in processor mode");

  // ****************************************
  // Coverage
  // ****************************************

  c_commit_enable: cover property (key_wr && st.staging[7:5] == `FCRB_UNLOCK_EN);
  c_window_high: cover property (key_wr && st.staging[3:2] == `FCRB_WIN_HIGH);
  c_standby_hit: cover property (standby_reset);
  c_serial_gate: cover property (serial_prog_mode && !other_port_input_en);
  c_strobe_drop: cover property (wr_done && !lo_lane);
endmodule : fcrb_top

`default_nettype wire
